// >>> src/gcc_pkg.sv
/*
  gcc_pkg: constants, command codes, register map and shared types
  of the gpio command control block.
  assumes: included by every gcc_ design file through gcc_pkg::*.
*/
package gcc_pkg;

  // ==========================================================
  // widths and counts
  localparam int GCC_NPINS = 8;        // controllable pins
  localparam int GCC_PARAM_W = 32;     // protocol mask width
  localparam int GCC_BYTE_W = 8;       // one stream byte
  localparam int GCC_PARAM_BYTES = 8;  // two params after code
  localparam int GCC_RESP_W = 40;      // code plus one param
  localparam logic [2:0] GCC_RESP_LEN_OK = 3'h5;   // valid reply
  localparam logic [2:0] GCC_RESP_LEN_BAD = 3'h1;  // invalid reply
  localparam logic [3:0] GCC_CNT_LAST = 4'h7;      // last param byte

  // ==========================================================
  // command codes
  localparam logic [7:0] GCC_CMD_GET_FUNC = 8'h10;
  localparam logic [7:0] GCC_CMD_GET_DIR = 8'h11;
  localparam logic [7:0] GCC_CMD_GET_LVL = 8'h12;
  localparam logic [7:0] GCC_CMD_GET_STATE = 8'h13;
  localparam logic [7:0] GCC_CMD_SET_DIR = 8'h19;
  localparam logic [7:0] GCC_CMD_SET_LVL = 8'h1a;
  localparam logic [7:0] GCC_CMD_SET_STATE = 8'h1b;
  localparam logic [7:0] GCC_RESP_INVALID = 8'hff;

  // ==========================================================
  // power-up defaults: all gpio, all input, all active low
  localparam logic [7:0] GCC_DEF_FUNC = 8'hff;
  localparam logic [7:0] GCC_DEF_DIR = 8'h00;
  localparam logic [7:0] GCC_DEF_LVL = 8'hff;
  localparam logic [7:0] GCC_DEF_STATE = 8'h00;

  // ==========================================================
  // register map, byte addresses
  localparam int GCC_AW = 8;
  localparam logic [7:0] GCC_REG_FUNC = 8'h00;      // pin functions
  localparam logic [7:0] GCC_REG_BOOT_DIR = 8'h04;  // boot directions
  localparam logic [7:0] GCC_REG_BOOT_LVL = 8'h08;  // boot levels
  localparam logic [7:0] GCC_REG_CTRL = 8'h0c;      // control
  localparam logic [7:0] GCC_REG_DIR = 8'h10;       // live directions
  localparam logic [7:0] GCC_REG_LVL = 8'h14;       // live levels
  localparam logic [7:0] GCC_REG_STATE = 8'h18;     // live states
  localparam logic [7:0] GCC_REG_PINS = 8'h1c;      // raw pin levels
  localparam int GCC_CTRL_DIS_BIT = 0;     // control port disabled
  localparam int GCC_CTRL_RELOAD_BIT = 1;  // write 1: reboot reload

  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] code;
    logic [31:0] mask;
    logic [31:0] value;
  } gcc_frame_t;

  typedef struct packed {
    logic [7:0] func;
    logic [7:0] dir;
    logic [7:0] lvl;
    logic [7:0] state;
  } gcc_pin_cfg_t;

  typedef enum logic [1:0] {ST_CODE, ST_PARAM, ST_EXEC, ST_RESP}
    gcc_state_t;

endpackage

// >>> src/gcc_sync.sv
/*
  gcc_sync: two-flop synchroniser for a bus of slow pin levels.
  assumes: bits are independent levels; no word coherence needed.
*/
`timescale 1ns/1ps
module gcc_sync
  import gcc_pkg::*;
#(
  parameter int W = GCC_NPINS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // stages
  logic [W-1:0] meta_r; // first stage, read only by q_r
  logic [W-1:0] q_r;    // second stage

  // two flops in series
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule // gcc_sync

// >>> src/gcc_tx.sv
/*
  gcc_tx: response serialiser, sends up to five bytes, low byte first.
  assumes: load only while busy is low; sink may stall with tx_ready.
*/
`timescale 1ns/1ps
module gcc_tx
  import gcc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [2:0] load_len,
  input wire logic [GCC_RESP_W-1:0] load_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic busy
);

  // ==========================================================
  // state
  logic [GCC_RESP_W-1:0] data_r; // remaining bytes, next in low byte
  logic [2:0] cnt_r;             // bytes left
  logic valid_r;                 // byte on offer
  logic take;                    // sink accepts a byte

  assign take = valid_r & tx_ready;

  // shift out one byte per accepted handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_r <= '0;
      cnt_r <= '0;
      valid_r <= 1'b0;
    end else if (load) begin
      data_r <= load_data;
      cnt_r <= load_len;
      valid_r <= 1'b1;
    end else if (take) begin
      data_r <= data_r >> GCC_BYTE_W;
      cnt_r <= cnt_r - 3'h1;
      valid_r <= (cnt_r != 3'h1);
    end
  end

  assign tx_valid = valid_r;
  assign tx_data = data_r[7:0];
  assign busy = valid_r;

endmodule // gcc_tx

// >>> src/gcc_top.sv
/*
  gcc_top: gpio command control. takes 9-byte commands from a byte
  stream, drives eight pins, answers with 5 bytes or one 0xff byte.
  assumes: the network stack delivers command bytes in order on
  rx_valid/rx_ready and drains replies on tx_valid/tx_ready; the
  register port is the configuration channel.
*/
`timescale 1ns/1ps
// Behaviour
// RULE1 - boot: all gpio, input, active low
// RULE2 - boot dir and level from config registers
// RULE3 - 32-bit masks, only pins 0..7 act
// RULE4 - parameters little endian, pin 0 first
// RULE5 - non-gpio bits ignored on set, undefined on get
// RULE6 - host sends code plus two words
// RULE7 - udp keeps one command in one datagram
// RULE8 - valid command: echo code plus word
// RULE9 - invalid command: single 0xff byte
// RULE10 - host waits for reply before next
// RULE11 - four consecutive query codes decoded
// RULE12 - unused parameter bytes are disregarded
// RULE13 - function cannot change through command port
// RULE14 - runtime changes are volatile only
// RULE15 - function word: one means user gpio
// RULE16 - direction word: one means output
// RULE17 - level word: one means active low
// RULE18 - state word: one means active
// RULE19 - set direction updates masked pins only
// RULE20 - set level updates masked pins only
// RULE21 - set state updates masked pins only
// RULE22 - disabled port offers no interface; the code keeps rx_ready high and drops the bytes without a reply
// RULE23 - set state replies all states
// RULE24 - unknown codes are invalid
module gcc_top
  import gcc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [GCC_NPINS-1:0] gpio_in,
  output logic [GCC_NPINS-1:0] gpio_out,
  output logic [GCC_NPINS-1:0] gpio_oe,
  input wire logic [GCC_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ==========================================================
  // helpers
  // masked update of one 8-bit field, foreign pins held
  function automatic logic [7:0] upd(input logic [7:0] old,
      input logic [7:0] mask, input logic [7:0] val);
    upd = (old & ~mask) | (val & mask);
  endfunction

  // widen an 8-pin word to a protocol word, upper pins read zero
  function automatic logic [31:0] wide(input logic [7:0] w);
    wide = {24'h0, w};
  endfunction

  // ==========================================================
  // state
  gcc_state_t st_r, st_nxt;       // command sequencer
  gcc_frame_t frm_r;              // collected command
  gcc_pin_cfg_t cfg_r;            // live pin configuration
  logic [7:0] boot_dir_r;         // boot directions
  logic [7:0] boot_lvl_r;         // boot levels
  logic dis_r;                    // control port disabled
  logic [3:0] cnt_r;              // parameter byte count
  logic rx_ready_r;               // byte intake open
  logic [31:0] rdata_r;           // read data, one cycle late
  logic [7:0] out_r;              // pin output levels
  logic [7:0] oe_r;               // pin output enables
  logic [7:0] pin_s;              // synchronised pin levels
  logic tx_busy;                  // serialiser still sending

  // ==========================================================
  // decode
  logic rx_take;        // byte accepted
  logic code_ok;        // command code recognised
  logic is_set_dir;
  logic is_set_lvl;
  logic is_set_state;
  logic [7:0] eff_mask; // pins both masked and gpio
  logic [7:0] live_state; // state seen by the host
  logic [7:0] cur_state;  // state before this command
  logic [31:0] resp_word; // reply word for the executed command
  logic [2:0] resp_len;
  logic [GCC_RESP_W-1:0] resp_data;
  logic load;           // start a reply
  logic wr_ctrl;
  logic reload;         // reboot-style reload of volatile state

  assign rx_take = rx_valid & rx_ready_r;
  assign is_set_dir = frm_r.code == GCC_CMD_SET_DIR;
  assign is_set_lvl = frm_r.code == GCC_CMD_SET_LVL;
  assign is_set_state = frm_r.code == GCC_CMD_SET_STATE;
  assign code_ok = (frm_r.code == GCC_CMD_GET_FUNC) // [RULE11]
    | (frm_r.code == GCC_CMD_GET_DIR)
    | (frm_r.code == GCC_CMD_GET_LVL)
    | (frm_r.code == GCC_CMD_GET_STATE)
    | is_set_dir | is_set_lvl | is_set_state;
  // mask bits above pin 7 and non-gpio pins drop out here
  assign eff_mask = frm_r.mask[7:0] & cfg_r.func; // [RULE3] [RULE5]
  // input pins report their pin, seen through the active level
  assign cur_state = (cfg_r.state & cfg_r.dir)
    | ((pin_s ^ cfg_r.lvl) & ~cfg_r.dir);
  // set state on an input stores the bit, the reply still shows the pin
  assign live_state = is_set_state
    ? ((upd(cfg_r.state, eff_mask, frm_r.value[7:0]) & cfg_r.dir)
      | ((pin_s ^ cfg_r.lvl) & ~cfg_r.dir)) : cur_state;

  // reply word is the value after the update, foreign pins zero
  // queries never look at the mask or value bytes [RULE12]
  always_comb begin
    resp_word = '0;
    unique case (frm_r.code)
      GCC_CMD_GET_FUNC: resp_word = wide(cfg_r.func); // [RULE15]
      GCC_CMD_GET_DIR: resp_word = wide(cfg_r.dir & cfg_r.func);
      GCC_CMD_GET_LVL: resp_word = wide(cfg_r.lvl & cfg_r.func);
      GCC_CMD_GET_STATE:
        resp_word = wide(cur_state & cfg_r.func); // [RULE18]
      GCC_CMD_SET_DIR: // [RULE16] [RULE19]
        resp_word = wide(upd(cfg_r.dir, eff_mask, frm_r.value[7:0])
          & cfg_r.func);
      GCC_CMD_SET_LVL: // [RULE17] [RULE20]
        resp_word = wide(upd(cfg_r.lvl, eff_mask, frm_r.value[7:0])
          & cfg_r.func);
      GCC_CMD_SET_STATE:
        resp_word = wide(live_state & cfg_r.func); // [RULE23]
      default: resp_word = '0; // any other code byte
    endcase
  end

  // code echoed first, then the word low byte first
  assign resp_len = code_ok ? GCC_RESP_LEN_OK
    : GCC_RESP_LEN_BAD; // [RULE8] [RULE9] [RULE24]
  assign resp_data = code_ok ? {resp_word, frm_r.code} // [RULE4]
    : {32'h0, GCC_RESP_INVALID};
  assign load = (st_r == ST_EXEC);
  assign wr_ctrl = reg_wr & (reg_addr == GCC_REG_CTRL);
  assign reload = wr_ctrl & reg_wdata[GCC_CTRL_RELOAD_BIT];

  // ==========================================================
  // sequencer
  // one command in flight; intake closes until reply is gone
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_CODE: if (rx_take && !dis_r) st_nxt = ST_PARAM;
      ST_PARAM:
        if (dis_r) st_nxt = ST_CODE; // [RULE22]
        else if (rx_take && cnt_r == GCC_CNT_LAST) st_nxt = ST_EXEC;
      ST_EXEC: st_nxt = ST_RESP;
      ST_RESP: if (!tx_busy) st_nxt = ST_CODE; // [RULE10]
    endcase
  end

  // state register and intake flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_CODE;
      rx_ready_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      // disabled port keeps draining so the stack never hangs
      rx_ready_r <= (st_nxt == ST_CODE) | (st_nxt == ST_PARAM);
    end
  end

  // collect code and both parameter words, low byte first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frm_r <= '0;
      cnt_r <= '0;
    end else if (rx_take && st_r == ST_CODE) begin
      frm_r.code <= rx_data; // [RULE6]
      cnt_r <= '0;
    end else if (rx_take && st_r == ST_PARAM) begin
      {frm_r.value, frm_r.mask} <= // [RULE4]
        {rx_data, frm_r.value, frm_r.mask[31:8]};
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // ==========================================================
  // pin configuration, volatile
  // only dir, lvl and state move on commands; func never does
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r.dir <= GCC_DEF_DIR; // [RULE1]
      cfg_r.lvl <= GCC_DEF_LVL;
      cfg_r.state <= GCC_DEF_STATE;
    end else if (reload) begin
      cfg_r.dir <= boot_dir_r; // [RULE2] [RULE14]
      cfg_r.lvl <= boot_lvl_r;
      cfg_r.state <= GCC_DEF_STATE;
    end else if (load && is_set_dir) begin
      cfg_r.dir <= upd(cfg_r.dir, eff_mask, frm_r.value[7:0]);
    end else if (load && is_set_lvl) begin
      cfg_r.lvl <= upd(cfg_r.lvl, eff_mask, frm_r.value[7:0]);
    end else if (load && is_set_state) begin
      cfg_r.state <= upd(cfg_r.state, eff_mask,
        frm_r.value[7:0]); // [RULE21]
    end
  end

  // configuration channel: function and boot values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r.func <= GCC_DEF_FUNC; // [RULE1]
      boot_dir_r <= GCC_DEF_DIR;
      boot_lvl_r <= GCC_DEF_LVL;
      dis_r <= 1'b0;
    end else if (reg_wr) begin
      // the only path that can move a pin function
      if (reg_addr == GCC_REG_FUNC)
        cfg_r.func <= reg_wdata[7:0]; // [RULE13]
      if (reg_addr == GCC_REG_BOOT_DIR)
        boot_dir_r <= reg_wdata[7:0]; // [RULE2]
      if (reg_addr == GCC_REG_BOOT_LVL) boot_lvl_r <= reg_wdata[7:0];
      if (wr_ctrl) dis_r <= reg_wdata[GCC_CTRL_DIS_BIT]; // [RULE22]
    end
  end

  // ==========================================================
  // pins
  // active low outputs sit high when inactive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_r <= '0;
      oe_r <= '0;
    end else begin
      out_r <= cfg_r.state ^ cfg_r.lvl; // [RULE17]
      oe_r <= cfg_r.dir & cfg_r.func;   // [RULE16]
    end
  end

  // pins come from outside the clock domain
  gcc_sync #(.W(GCC_NPINS)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(gpio_in),
    .q(pin_s)
  );

  // reply serialiser
  gcc_tx u_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(load),
    .load_len(resp_len),
    .load_data(resp_data),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .busy(tx_busy)
  );

  // ==========================================================
  // register read port, unmapped reads give zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      GCC_REG_FUNC: rd_mux = wide(cfg_r.func);
      GCC_REG_BOOT_DIR: rd_mux = wide(boot_dir_r);
      GCC_REG_BOOT_LVL: rd_mux = wide(boot_lvl_r);
      GCC_REG_CTRL: rd_mux = {31'h0, dis_r};
      GCC_REG_DIR: rd_mux = wide(cfg_r.dir);
      GCC_REG_LVL: rd_mux = wide(cfg_r.lvl);
      GCC_REG_STATE: rd_mux = wide(cfg_r.state);
      GCC_REG_PINS: rd_mux = wide(pin_s);
      default: rd_mux = '0;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) rdata_r <= '0;
    else rdata_r <= reg_rd ? rd_mux : 32'h0;
  end

  assign rx_ready = rx_ready_r;
  assign gpio_out = out_r;
  assign gpio_oe = oe_r;
  assign reg_rdata = rdata_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_BOOT_DEFAULT: assert property ( // [RULE1]
    $fell(sys_rst) |-> cfg_r.func == GCC_DEF_FUNC
      && cfg_r.dir == GCC_DEF_DIR && cfg_r.lvl == GCC_DEF_LVL)
    else $error("boot defaults wrong");
  AST_RELOAD_BOOT: assert property ( // [RULE2]
    reload |=> cfg_r.dir == $past(boot_dir_r)
      && cfg_r.lvl == $past(boot_lvl_r))
    else $error("reload missed boot values");
  AST_HIGH_MASK: assert property ( // [RULE3]
    load && frm_r.mask[7:0] == 8'h00 && !reload |=> $stable(cfg_r.dir)
      && $stable(cfg_r.lvl) && $stable(cfg_r.state))
    else $error("mask reaches past pin 7");
  AST_OK_ECHO: assert property ( // [RULE8]
    load && code_ok |=> tx_valid && tx_data == $past(frm_r.code))
    else $error("code not echoed");
  AST_BAD_FF: assert property ( // [RULE9]
    load && !code_ok |=> tx_valid && tx_data == GCC_RESP_INVALID)
    else $error("invalid reply not 0xff");
  AST_BAD_ONE: assert property ( // [RULE9]
    st_r == ST_RESP && !code_ok && tx_valid && tx_ready |=> !tx_valid)
    else $error("invalid reply longer than one byte");
  AST_FUNC_FIXED: assert property ( // [RULE13]
    !(reg_wr && reg_addr == GCC_REG_FUNC) |=> $stable(cfg_r.func))
    else $error("function moved");
  AST_SET_DIR: assert property ( // [RULE19]
    load && is_set_dir && !reload |=> cfg_r.dir == upd($past(cfg_r.dir),
      $past(eff_mask), $past(frm_r.value[7:0])))
    else $error("set direction wrong");
  AST_SET_LVL: assert property ( // [RULE20]
    load && is_set_lvl && !reload |=> (cfg_r.lvl
      & ~$past(eff_mask)) == ($past(cfg_r.lvl) & ~$past(eff_mask)))
    else $error("unmasked level moved");
  AST_SET_STATE: assert property ( // [RULE21]
    load && is_set_state && !reload |=> (cfg_r.state
      & $past(eff_mask)) == ($past(frm_r.value[7:0] & eff_mask)))
    else $error("set state wrong");
  AST_DISABLED: assert property ( // [RULE22]
    dis_r && st_r == ST_CODE |=> st_r == ST_CODE)
    else $error("disabled port took a command");
  AST_ONE_INFLIGHT: assert property ( // [RULE10]
    st_r == ST_RESP |-> !rx_ready_r)
    else $error("intake open during reply");
  AST_PIN_DRIVE: assert property ( // [RULE16]
    ##1 gpio_oe == $past(cfg_r.dir & cfg_r.func))
    else $error("output enable wrong");

  COV_QUERY: cover property (load && frm_r.code == GCC_CMD_GET_FUNC);
  COV_SET_STATE: cover property (load && is_set_state);
  COV_INVALID: cover property (load && !code_ok);
  COV_STALL: cover property (tx_valid && !tx_ready ##1 tx_valid);

endmodule // gcc_top

// >>> dv/gcc_host.sv
/*
  gcc_host: behavioural host application on the far side of the
  command byte stream; sends whole commands and drains the replies.
  assumes: called from the bench right after a rising clock edge;
  the bench seeds $urandom once before any traffic.
*/
`timescale 1ns/1ps
module gcc_host
  import gcc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  int taken = 0; // reply bytes drained so far

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // ==========================================================
  // reply sink
  // stalls about one cycle in four so held reply bytes get exercised
  always @(posedge clk) begin
    tx_ready <= !sys_rst && ($urandom_range(3) != 0);
    if (tx_valid && tx_ready) begin
      taken <= taken + 1;
    end
  end

  // ==========================================================
  // command source
  // one frame, then wait for the whole reply before returning
  task automatic send(input gcc_frame_t f, input int n_resp,
                      output bit ok);
    logic [71:0] bytes;
    int start;
    int guard;
    bytes = {f.value, f.mask, f.code}; // code first, words low byte first
    start = taken;
    ok = 1'b1;
    for (int k = 0; k < 9; k++) begin // all nine bytes in one burst
      rx_valid <= 1'b1;
      rx_data <= bytes[8*k +: 8];
      guard = 0;
      do begin
        @(posedge clk);
        guard++;
      end while (!rx_ready && guard < 100);
      if (!rx_ready) ok = 1'b0;
    end
    rx_valid <= 1'b0;
    rx_data <= ~bytes[71:64]; // released line must not keep the last byte
    guard = 0;
    while ((taken < start + n_resp || guard < 20 * int'(n_resp == 0))
           && guard < 300) begin // no next command before reply
      @(posedge clk);
      guard++;
    end
    if (taken < start + n_resp) ok = 1'b0;
  endtask
endmodule // gcc_host

// >>> dv/test_gpio_command_control.sv
/*
  test_gpio_command_control: self-checking bench for gcc_top with a
  reference copy of the pin settings and a queue of expected bytes.
  assumes: gcc_host model drives the stream; registers via the port.
*/
`timescale 1ns/1ps
module test_gpio_command_control
  import gcc_pkg::*;
;
  logic clk, sys_rst, rx_valid, rx_ready, tx_valid, tx_ready;
  logic reg_wr, reg_rd;
  logic [7:0] rx_data, tx_data, gpio_in, gpio_out, gpio_oe, reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] m_func, m_dir, m_lvl, m_state; // reference settings
  logic [7:0] exp_q[$]; // reply bytes still owed
  bit dis = 1'b0; // command port disabled in the model
  logic [7:0] ra[8] = '{GCC_REG_FUNC, GCC_REG_BOOT_DIR, GCC_REG_BOOT_LVL,
    GCC_REG_CTRL, GCC_REG_DIR, GCC_REG_LVL, GCC_REG_STATE, 8'h20};
  logic [7:0] rv[8] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00,
    8'h00};
  logic [7:0] codes[7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1a,
    8'h1b};
  logic [7:0] bad[5] = '{8'h00, 8'h14, 8'h18, 8'h1c, 8'hff};

  // ==========================================================
  // clock and instances
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  gcc_top DUT (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  gcc_host host (.clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk); // next strobe never lands in the same step
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(reg_rdata, e, "register read");
  endtask

  // ==========================================================
  // one command: update the model, note the reply, send, check pins
  task automatic cmd(input logic [7:0] code, input logic [31:0] mk, vl);
    logic [7:0] m;
    logic [7:0] w;
    bit good;
    bit ok;
    gcc_frame_t f;
    gpio_in <= 8'($urandom);
    repeat (3) @(posedge clk); // let the pin synchroniser settle
    m = mk[7:0] & m_func; // upper mask bits and non-gpio pins ignored
    good = 1'b1;
    if (!dis) begin
      case (code)
        GCC_CMD_SET_DIR: m_dir = (m_dir & ~m) | (vl[7:0] & m);
        GCC_CMD_SET_LVL: m_lvl = (m_lvl & ~m) | (vl[7:0] & m);
        GCC_CMD_SET_STATE: m_state = (m_state & ~m) | (vl[7:0] & m);
        8'h10, 8'h11, 8'h12, 8'h13: good = 1'b1;
        default: good = 1'b0;
      endcase
    end
    case (code)
      GCC_CMD_GET_FUNC: w = m_func;
      GCC_CMD_GET_DIR, GCC_CMD_SET_DIR: w = m_dir & m_func;
      GCC_CMD_GET_LVL, GCC_CMD_SET_LVL: w = m_lvl & m_func;
      default: w = ((m_dir & m_state) | (~m_dir & (gpio_in ^ m_lvl)))
                   & m_func;
    endcase
    if (!dis && good) begin // echo plus word, low byte first
      exp_q.push_back(code);
      exp_q.push_back(w);
      repeat (3) exp_q.push_back(8'h00);
    end else if (!dis) begin
      exp_q.push_back(GCC_RESP_INVALID);
    end
    f = '{code, mk, vl};
    host.send(f, dis ? 0 : (good ? 5 : 1), ok);
    check(32'(ok), 32'h1, "command stream handshake");
    if (!ok) conclude();
    check(gpio_oe, m_dir & m_func, "output enables");
    check(gpio_out & m_func, (m_state ^ m_lvl) & m_func, "pin levels");
  endtask

  // ==========================================================
  // reply monitor: each taken byte against the oldest note
  always @(posedge clk) begin
    if (!sys_rst && tx_valid && tx_ready) begin
      if (exp_q.size() == 0) begin
        check(32'(tx_data), 32'h100, "unexpected reply byte");
      end else begin
        check(32'(tx_data), 32'(exp_q.pop_front()), "reply byte");
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(8981));
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    gpio_in = 8'h00;
    m_func = GCC_DEF_FUNC;
    m_dir = GCC_DEF_DIR;
    m_lvl = GCC_DEF_LVL;
    m_state = GCC_DEF_STATE;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check(gpio_oe, 8'h00, "boot enables");
    check(gpio_out, 8'hff, "boot levels");
    for (int i = 0; i < 8; i++) reg_read(ra[i], {24'h0, rv[i]});
    for (int c = 0; c < 4; c++) cmd(codes[c], $urandom, $urandom);
    cmd(GCC_CMD_SET_DIR, 32'hffff_ff0f, 32'hffff_ff05);
    cmd(GCC_CMD_SET_STATE, 32'hffff_ff00, 32'hffff_ffff);
    cmd(GCC_CMD_SET_LVL, 32'h0000_003c, 32'h0000_0014);
    cmd(GCC_CMD_SET_STATE, 32'h0000_00ff, 32'h0000_00a5);
    foreach (bad[i]) cmd(bad[i], $urandom, $urandom);
    for (int i = 0; i < 24; i++) begin // random back-to-back mix
      cmd($urandom_range(1) ? codes[$urandom_range(6)] : 8'($urandom),
          $urandom, $urandom);
    end
    // pin functions change only through registers
    reg_write(GCC_REG_FUNC, 32'h0000_000f);
    m_func = 8'h0f;
    cmd(GCC_CMD_GET_FUNC, 32'h0, 32'h0);
    cmd(GCC_CMD_SET_DIR, 32'h0000_00ff, 32'h0000_00ff);
    cmd(GCC_CMD_SET_STATE, 32'h0000_00ff, $urandom);
    // reboot reload drops runtime changes
    reg_write(GCC_REG_BOOT_DIR, 32'h0000_000a);
    reg_write(GCC_REG_BOOT_LVL, 32'h0000_0005);
    reg_write(GCC_REG_CTRL, 32'h0000_0002);
    m_dir = 8'h0a;
    m_lvl = 8'h05;
    m_state = 8'h00;
    reg_write(GCC_REG_STATE, 32'h0000_00ff); // read-only, ignored
    reg_read(GCC_REG_STATE, 32'h0);
    reg_read(GCC_REG_DIR, 32'h0000_000a);
    for (int c = 1; c < 4; c++) cmd(codes[c], $urandom, $urandom);
    // disabled port swallows commands silently
    reg_write(GCC_REG_CTRL, 32'h0000_0001);
    dis = 1'b1;
    cmd(GCC_CMD_SET_DIR, 32'h0000_00ff, 32'h0000_00ff);
    reg_write(GCC_REG_CTRL, 32'h0000_0000);
    dis = 1'b0;
    cmd(GCC_CMD_GET_DIR, $urandom, $urandom);
    repeat (10) @(posedge clk);
    check(exp_q.size(), 32'h0, "replies outstanding");
    conclude();
  end
endmodule // test_gpio_command_control
